// file: design/hsq_cfg.svh
// register map, field positions, reset values and timing for the homing sequencer
`ifndef HSQ_CFG_SVH
`define HSQ_CFG_SVH
`define HSQ_SPD_W        16
`define HSQ_TICK_W       24
`define HSQ_ADDR_W       8
`define HSQ_OFF_CTRL     8'h00
`define HSQ_OFF_METHOD   8'h04
`define HSQ_OFF_HIGH     8'h08
`define HSQ_OFF_LOW      8'h0c
`define HSQ_OFF_ACC      8'h10
`define HSQ_OFF_STAT     8'h14
`define HSQ_CTRL_START   0
`define HSQ_CTRL_ABORT   1
`define HSQ_ST_BUSY      0
`define HSQ_ST_DONE      1
`define HSQ_ST_ERR       2
`define HSQ_ST_LIMIT     3
`define HSQ_ST_STEP      4
`define HSQ_ST_DIR       6
`define HSQ_RST_METHOD   8'h02
`define HSQ_RST_HIGH     16'h0064
`define HSQ_RST_LOW      16'h000a
`define HSQ_RST_ACC      16'h0001
`define HSQ_M2           8'h02
`define HSQ_M3           8'h03
`define HSQ_M4           8'h04
`define HSQ_M5           8'h05
`define HSQ_M6           8'h06
`define HSQ_M7           8'h07
`define HSQ_M8           8'h08
`define HSQ_M9           8'h09
`define HSQ_PATH_LOW     2'h0
`define HSQ_PATH_HIGH    2'h1
`define HSQ_PATH_LIM     2'h2
`define HSQ_STEP_W       2
`define HSQ_CLK_NS       8
`define HSQ_TICK_NS      1000000
`endif

// file: design/hsq_pkg.sv
// types of the homing sequencer
`include "hsq_cfg.svh"
package hsq_pkg;
   typedef enum logic [3:0] {
      HSQ_IDLE  = 4'h1,
      HSQ_RUN   = 4'h2,
      HSQ_ZSEEK = 4'h4,
      HSQ_DECEL = 4'h8
   } hsq_fsm_e;

   typedef struct packed {
      logic dir_rev;
      logic hi;
      logic want_rise;
      logic last;
   } hsq_step_s;

   typedef struct packed {
      logic [`HSQ_ADDR_W-1:0] addr;
      logic [31:0]            wdata;
      logic                   wr;
      logic                   rd;
   } hsq_bus_s;

   typedef struct packed {
      logic [`HSQ_SPD_W-1:0] speed;
      logic                  dir_rev;
      logic                  busy;
      logic                  done;
   } hsq_motion_s;

   typedef struct packed {
      logic [2:0] pot;
      logic [2:0] home;
      logic [2:0] idx;
   } hsq_sync_s;

   typedef struct packed {
      hsq_sync_s             sy;
      hsq_fsm_e              st;
      logic [`HSQ_STEP_W-1:0] step;
      logic [1:0]            path;
      logic                  fin;
      logic                  done;
      logic                  err;
      logic                  lim;
      logic                  dir_rev;
      logic [`HSQ_SPD_W-1:0] cnt;
      logic [`HSQ_SPD_W-1:0] base;
      logic [`HSQ_SPD_W-1:0] speed;
      logic [`HSQ_TICK_W-1:0] tick;
      logic [7:0]            method;
      logic [`HSQ_SPD_W-1:0] hi_spd;
      logic [`HSQ_SPD_W-1:0] lo_spd;
      logic [`HSQ_SPD_W-1:0] acc;
      logic [31:0]           rdata;
   } hsq_state_s;
endpackage

// file: design/hsq_top.sv
// homing sequencer for methods 2 to 9 with register port and motion command
// Operation
// - method 2 decelerates on forward overtravel, homes on index
// - method 2 low: forward fast, reverse slow, index
// - method 2 high: reverse slow to fall, index
// - methods 3 to 9 use home switch, index
// - method 3/7 low: forward fast, reverse slow, index
// - methods 3/7 high: reverse slow to fall, index
// - method 4 low: fwd fast, rev slow, fwd slow
// - method 4 high: rev slow, fwd slow, index
// - method 5 low: rev fast, fwd slow, index
// - method 5 high: forward slow to fall, index
// - method 6 low: rev fast, fwd slow, rev slow
// - method 6 high: fwd slow, rev slow, index
// - methods 7/8 limit: reverse fast to rising edge
// - method 7 limit: rev slow, fwd slow, reverse
// - method 8 low: fwd fast, rev slow, fwd slow
// - method 8 limit: rev slow, fwd slow, index
// - method 8 high: rev slow, fwd slow, index
// - method 9 low: fwd fast, fwd slow, rev slow
// - method 9 limit: rev fast, fwd slow, rev slow
// - method 9 high: fwd fast to fall, rev slow
//
// Design decisions made here: the plain strobed port and the register offsets.
`include "hsq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module hsq_top
   import hsq_pkg::*;
#(
   parameter int unsigned TICK_CYC = `HSQ_TICK_NS / `HSQ_CLK_NS
) (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire hsq_bus_s    bus_i,
   output logic [31:0]      reg_rdata_o,
   input  wire logic        forward_overtravel_switch_i,
   input  wire logic        home_switch_input_i,
   input  wire logic        index_pulse_i,
   output hsq_motion_s      motion_o
);
   localparam logic FWD  = 1'b0;
   localparam logic REV  = 1'b1;
   localparam logic HI   = 1'b1;
   localparam logic LO   = 1'b0;
   localparam logic RISE = 1'b1;
   localparam logic FALL = 1'b0;
   localparam logic LAST = 1'b1;
   localparam logic MORE = 1'b0;
   localparam logic [`HSQ_TICK_W-1:0] TICK_END = `HSQ_TICK_W'(TICK_CYC - 1);
   localparam hsq_state_s RST = '{st: HSQ_IDLE, method: `HSQ_RST_METHOD, hi_spd: `HSQ_RST_HIGH,
                                  lo_spd: `HSQ_RST_LOW, acc: `HSQ_RST_ACC, default: '0};

   hsq_state_s q;
   hsq_state_s d;
   hsq_step_s  cur;
   hsq_step_s  nxt;
   hsq_step_s  fst;
   logic       sw_lvl;
   logic       sw_rise;
   logic       sw_fall;
   logic       idx_rise;
   logic       lim_rise;
   logic       tick;
   logic       edge_hit;
   logic       start_req;
   logic       abort_req;
   logic       meth_ok;
   logic       start_ok;
   logic       lim_arm;
   logic       dec_end;

   function automatic hsq_step_s mk(input logic rev, input logic hi, input logic rise, input logic last);
      mk = '{dir_rev: rev, hi: hi, want_rise: rise, last: last};
   endfunction

   // one step of the trajectory for a method, start path and step index
   function automatic hsq_step_s step_of(input logic [7:0] m, input logic [1:0] p,
                                         input logic [`HSQ_STEP_W-1:0] i);
      hsq_step_s s;
      s = mk(REV, LO, FALL, LAST);
      case (m)
         `HSQ_M2, `HSQ_M3, `HSQ_M7: begin
            if (m == `HSQ_M7 && p == `HSQ_PATH_LIM) begin
               case (i)
                  2'h0:    s = mk(REV, HI, RISE, MORE);
                  2'h1:    s = mk(REV, LO, FALL, MORE);
                  2'h2:    s = mk(FWD, LO, RISE, MORE);
                  default: s = mk(REV, LO, FALL, LAST);
               endcase
            end else if (p == `HSQ_PATH_LOW && i == 2'h0) begin
               s = mk(FWD, HI, RISE, MORE);
            end else begin
               s = mk(REV, LO, FALL, LAST);
            end
         end
         `HSQ_M4, `HSQ_M8: begin
            if (p == `HSQ_PATH_HIGH) begin
               s = (i == 2'h0) ? mk(REV, LO, FALL, MORE) : mk(FWD, LO, RISE, LAST);
            end else begin
               case (i)
                  2'h0:    s = (p == `HSQ_PATH_LIM) ? mk(REV, HI, RISE, MORE)
                                                    : mk(FWD, HI, RISE, MORE);
                  2'h1:    s = mk(REV, LO, FALL, MORE);
                  default: s = mk(FWD, LO, RISE, LAST);
               endcase
            end
         end
         `HSQ_M5: begin
            if (p == `HSQ_PATH_LOW && i == 2'h0) begin
               s = mk(REV, HI, RISE, MORE);
            end else begin
               s = mk(FWD, LO, FALL, LAST);
            end
         end
         `HSQ_M6, `HSQ_M9: begin
            if (p == `HSQ_PATH_HIGH) begin
               s = (i == 2'h0) ? mk(FWD, (m == `HSQ_M9), FALL, MORE)
                               : mk(REV, LO, RISE, LAST);
            end else begin
               case (i)
                  2'h0:    s = (m == `HSQ_M9 && p == `HSQ_PATH_LOW) ? mk(FWD, HI, RISE, MORE)
                                                                    : mk(REV, HI, RISE, MORE);
                  2'h1:    s = mk(FWD, LO, FALL, MORE);
                  default: s = mk(REV, LO, RISE, LAST);
               endcase
            end
         end
         default: s = mk(REV, LO, FALL, LAST);
      endcase
      return s;
   endfunction

   // decision logic reads only the second and third synchroniser stages
   always_comb begin
      sw_lvl   = (q.method == `HSQ_M2) ? q.sy.pot[1] : q.sy.home[1];
      sw_rise  = (q.method == `HSQ_M2) ? (q.sy.pot[1] & ~q.sy.pot[2])
                                       : (q.sy.home[1] & ~q.sy.home[2]);
      sw_fall  = (q.method == `HSQ_M2) ? (~q.sy.pot[1] & q.sy.pot[2])
                                       : (~q.sy.home[1] & q.sy.home[2]);
      idx_rise = q.sy.idx[1] & ~q.sy.idx[2];
      lim_rise = q.sy.pot[1] & ~q.sy.pot[2];
      tick     = (q.tick == TICK_END);
      cur      = step_of(q.method, q.path, q.step);
      nxt      = step_of(q.method, q.path, q.step + 2'h1);
      fst      = step_of(q.method, sw_lvl ? `HSQ_PATH_HIGH : `HSQ_PATH_LOW, '0);
      dec_end  = q.st == HSQ_DECEL && tick && (q.cnt <= q.acc || q.acc == '0);
      edge_hit = cur.want_rise ? sw_rise : sw_fall;
      meth_ok  = (q.method >= `HSQ_M2) && (q.method <= `HSQ_M9);
      start_req = bus_i.wr && bus_i.addr == `HSQ_OFF_CTRL && bus_i.wdata[`HSQ_CTRL_START];
      abort_req = bus_i.wr && bus_i.addr == `HSQ_OFF_CTRL && bus_i.wdata[`HSQ_CTRL_ABORT];
      start_ok  = start_req && q.st == HSQ_IDLE && meth_ok;
      lim_arm   = (q.method == `HSQ_M7 || q.method == `HSQ_M8 || q.method == `HSQ_M9)
                  && q.path == `HSQ_PATH_LOW && q.step == '0;
   end

   always_comb begin
      d = q;
      d.sy.pot  = {q.sy.pot[1:0], forward_overtravel_switch_i};
      d.sy.home = {q.sy.home[1:0], home_switch_input_i};
      d.sy.idx  = {q.sy.idx[1:0], index_pulse_i};
      d.tick    = tick ? '0 : q.tick + `HSQ_TICK_W'(1);
      // register port
      if (bus_i.wr && q.st == HSQ_IDLE) begin
         unique case (bus_i.addr)
            `HSQ_OFF_METHOD: d.method = bus_i.wdata[7:0];
            `HSQ_OFF_HIGH:   d.hi_spd = bus_i.wdata[`HSQ_SPD_W-1:0];
            `HSQ_OFF_LOW:    d.lo_spd = bus_i.wdata[`HSQ_SPD_W-1:0];
            `HSQ_OFF_ACC:    d.acc    = bus_i.wdata[`HSQ_SPD_W-1:0];
            default:         d.method = q.method;
         endcase
      end
      d.rdata = '0;
      if (bus_i.rd) begin
         unique case (bus_i.addr)
            `HSQ_OFF_METHOD: d.rdata = {24'h000000, q.method};
            `HSQ_OFF_HIGH:   d.rdata = {16'h0000, q.hi_spd};
            `HSQ_OFF_LOW:    d.rdata = {16'h0000, q.lo_spd};
            `HSQ_OFF_ACC:    d.rdata = {16'h0000, q.acc};
            `HSQ_OFF_STAT: begin
               d.rdata[`HSQ_ST_BUSY] = (q.st != HSQ_IDLE);
               d.rdata[`HSQ_ST_DONE] = q.done;
               d.rdata[`HSQ_ST_ERR]  = q.err;
               d.rdata[`HSQ_ST_LIMIT] = q.lim;
               d.rdata[`HSQ_ST_STEP +: `HSQ_STEP_W] = q.step;
               d.rdata[`HSQ_ST_DIR]  = q.dir_rev;
            end
            default:         d.rdata = '0;
         endcase
      end
      // sequencer
      unique case (q.st)
         HSQ_IDLE: begin
            if (start_req) begin
               d.err = ~meth_ok;
            end
            if (start_ok) begin
               d.done = 1'b0;
               d.lim  = 1'b0;
               d.step = '0;
               d.fin  = 1'b0;
               d.path = sw_lvl ? `HSQ_PATH_HIGH : `HSQ_PATH_LOW;
               d.st   = HSQ_RUN;
               d.dir_rev = fst.dir_rev;
               d.speed   = fst.hi ? q.hi_spd : q.lo_spd;
            end
         end
         HSQ_RUN: begin
            if (lim_arm && lim_rise) begin
               d.lim  = 1'b1;
               d.path = `HSQ_PATH_LIM;
               d.step = '0;
               d.fin  = 1'b0;
               d.cnt  = q.hi_spd;
               d.base = '0;
               d.st   = HSQ_DECEL;
            end else if (edge_hit && cur.last) begin
               d.st = HSQ_ZSEEK;
            end else if (edge_hit) begin
               d.step = q.step + 2'h1;
               d.fin  = 1'b0;
               d.st   = HSQ_DECEL;
               // reversal sheds the running speed, same direction sheds the difference
               if (nxt.dir_rev != cur.dir_rev) begin
                  d.cnt  = cur.hi ? q.hi_spd : q.lo_spd;
                  d.base = '0;
               end else begin
                  d.cnt  = q.hi_spd - q.lo_spd;
                  d.base = q.lo_spd;
               end
            end
         end
         HSQ_ZSEEK: begin
            if (idx_rise) begin
               d.fin  = 1'b1;
               d.cnt  = q.lo_spd;
               d.base = '0;
               d.st   = HSQ_DECEL;
            end
         end
         HSQ_DECEL: begin
            if (tick) begin
               if (q.cnt <= q.acc || q.acc == '0) begin
                  d.cnt = '0;
                  if (q.fin) begin
                     d.st    = HSQ_IDLE;
                     d.done  = 1'b1;
                     d.speed = '0;
                  end else begin
                     d.st      = HSQ_RUN;
                     d.dir_rev = cur.dir_rev;
                     d.speed   = cur.hi ? q.hi_spd : q.lo_spd;
                  end
               end else begin
                  d.cnt = q.cnt - q.acc;
               end
            end
            if (d.st == HSQ_DECEL) begin
               d.speed = `HSQ_SPD_W'(d.base + d.cnt);
            end
         end
         default: d.st = HSQ_IDLE;
      endcase
      if (abort_req) begin
         d.st    = HSQ_IDLE;
         d.speed = '0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata_o = q.rdata;
   assign motion_o    = '{speed: q.speed, dir_rev: q.dir_rev, busy: (q.st != HSQ_IDLE), done: q.done};

   logic m2_go;
   assign m2_go = start_ok && q.method == `HSQ_M2;

   AST_M2_LOW_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
      m2_go && !q.sy.pot[1] |=> q.st == HSQ_RUN && !q.dir_rev && q.speed == q.hi_spd)
      else $error("method 2 low start not forward fast");
   AST_M2_HIGH_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
      m2_go && q.sy.pot[1] |=> q.dir_rev && q.speed == q.lo_spd)
      else $error("method 2 high start not reverse slow");
   AST_M5_LOW_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_ok && q.method == `HSQ_M5 && !q.sy.home[1] |=> q.dir_rev && q.speed == q.hi_spd)
      else $error("method 5 low start not reverse fast");
   AST_M9_HIGH_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_ok && q.method == `HSQ_M9 && q.sy.home[1] |=> !q.dir_rev && q.speed == q.hi_spd)
      else $error("method 9 high start not forward fast");
   AST_EDGE_ADVANCE: assert property (@(posedge clk_i) disable iff (!resetn_i)
      q.st == HSQ_RUN && edge_hit && !(lim_arm && lim_rise) && !abort_req
      |=> q.st == HSQ_DECEL || q.st == HSQ_ZSEEK)
      else $error("switch edge did not advance the run");
   AST_INDEX_STOP: assert property (@(posedge clk_i) disable iff (!resetn_i)
      q.st == HSQ_ZSEEK && idx_rise && !abort_req |=> q.st == HSQ_DECEL && q.fin && q.cnt == q.lo_spd)
      else $error("index pulse did not stop the search");
   AST_LIMIT_REVERSE: assert property (@(posedge clk_i) disable iff (!resetn_i)
      q.st == HSQ_RUN && lim_arm && lim_rise && !abort_req
      |=> q.lim && q.st == HSQ_DECEL && q.path == `HSQ_PATH_LIM && q.cnt == q.hi_spd && !q.dir_rev)
      else $error("forward limit did not reverse");
   AST_DECEL_ENDS: assert property (@(posedge clk_i) disable iff (!resetn_i)
      q.st == HSQ_DECEL && tick && (q.cnt <= q.acc || q.acc == '0) && !q.fin && !abort_req
      |=> q.st == HSQ_RUN && q.speed == (cur.hi ? q.hi_spd : q.lo_spd))
      else $error("deceleration did not hand over to the next step");
   AST_SYNC_DELAY: assert property (@(posedge clk_i) disable iff (!resetn_i)
      // third stage still holds its reset value on the first edges
      idx_rise && $past(resetn_i, 3) |-> $past(index_pulse_i, 2) && !$past(index_pulse_i, 3))
      else $error("index edge not two stages late");
   AST_IDLE_STILL: assert property (@(posedge clk_i) disable iff (!resetn_i)
      $fell(motion_o.busy) |-> motion_o.speed == '0)
      else $error("motor left moving at idle");
   AST_LIMIT_FAST_BACK: assert property (@(posedge clk_i) disable iff (!resetn_i)
      dec_end && !q.fin && q.path == `HSQ_PATH_LIM && q.step == '0 && !abort_req
      |=> q.st == HSQ_RUN && q.dir_rev && q.speed == q.hi_spd)
      else $error("limit reversal not reverse fast");
   AST_M2_PATH: assert property (@(posedge clk_i) disable iff (!resetn_i)
      m2_go |=> q.path == ($past(q.sy.pot[1]) ? `HSQ_PATH_HIGH : `HSQ_PATH_LOW))
      else $error("method 2 path not taken from overtravel");
   AST_HOME_PATH: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_ok && q.method != `HSQ_M2 |=> q.path == ($past(q.sy.home[1]) ? `HSQ_PATH_HIGH : `HSQ_PATH_LOW))
      else $error("path not taken from home switch");
   AST_FWD_FAST_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_ok && q.method inside {`HSQ_M3, `HSQ_M4, `HSQ_M7, `HSQ_M8, `HSQ_M9} && !q.sy.home[1]
      |=> !q.dir_rev && q.speed == q.hi_spd)
      else $error("low start not forward fast");
   AST_M3_HIGH_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_ok && (q.method == `HSQ_M3 || q.method == `HSQ_M7) && q.sy.home[1] |=> q.dir_rev && q.speed == q.lo_spd)
      else $error("method 3 high start not reverse slow");
   AST_M4_HIGH_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_ok && q.method == `HSQ_M4 && q.sy.home[1] |=> q.dir_rev && q.speed == q.lo_spd)
      else $error("method 4 high start not reverse slow");
   AST_M5_HIGH_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_ok && q.method == `HSQ_M5 && q.sy.home[1] |=> !q.dir_rev && q.speed == q.lo_spd)
      else $error("method 5 high start not forward slow");
   AST_M6_LOW_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_ok && q.method == `HSQ_M6 && !q.sy.home[1] |=> q.dir_rev && q.speed == q.hi_spd)
      else $error("method 6 low start not reverse fast");
   AST_M6_HIGH_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_ok && q.method == `HSQ_M6 && q.sy.home[1] |=> !q.dir_rev && q.speed == q.lo_spd)
      else $error("method 6 high start not forward slow");
   AST_M8_HIGH_START: assert property (@(posedge clk_i) disable iff (!resetn_i)
      start_ok && q.method == `HSQ_M8 && q.sy.home[1] |=> q.dir_rev && q.speed == q.lo_spd)
      else $error("method 8 high start not reverse slow");
   AST_DECEL_RAMP: assert property (@(posedge clk_i) disable iff (!resetn_i)
      q.st == HSQ_DECEL && tick && !dec_end && !abort_req
      |=> q.st == HSQ_DECEL && q.cnt == $past(q.cnt) - $past(q.acc))
      else $error("deceleration step not one acceleration unit");
   AST_HOME_DONE: assert property (@(posedge clk_i) disable iff (!resetn_i)
      dec_end && q.fin && !abort_req |=> q.st == HSQ_IDLE && q.done && q.speed == '0)
      else $error("final stop did not finish homing");
   AST_LAST_EDGE_SEEK: assert property (@(posedge clk_i) disable iff (!resetn_i)
      q.st == HSQ_RUN && edge_hit && cur.last && !(lim_arm && lim_rise) && !abort_req |=> q.st == HSQ_ZSEEK)
      else $error("last switch edge did not arm index search");
   AST_ABORT_STOP: assert property (@(posedge clk_i) disable iff (!resetn_i)
      abort_req |=> q.st == HSQ_IDLE && q.speed == '0)
      else $error("abort did not stop the motor");
   AST_READ_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
      !bus_i.rd |=> reg_rdata_o == '0)
      else $error("read data held without a read");

   COV_M4_DONE: cover property (@(posedge clk_i) disable iff (!resetn_i)
      q.method == `HSQ_M4 && $rose(q.done));
   COV_M7_LIMIT: cover property (@(posedge clk_i) disable iff (!resetn_i)
      q.method == `HSQ_M7 && q.lim && $rose(q.done));
   COV_M9_HIGH: cover property (@(posedge clk_i) disable iff (!resetn_i)
      q.method == `HSQ_M9 && q.path == `HSQ_PATH_HIGH && $rose(q.done));
   COV_M2_HIGH: cover property (@(posedge clk_i) disable iff (!resetn_i)
      q.method == `HSQ_M2 && q.path == `HSQ_PATH_HIGH && $rose(q.done));
   COV_ABORT_RUN: cover property (@(posedge clk_i) disable iff (!resetn_i)
      abort_req && q.st != HSQ_IDLE);
endmodule
`default_nettype wire

// file: tb/hsq_motor_model.sv
// behavioural motor, encoder index and switch model for the homing sequencer bench
`timescale 1ns/100ps
`default_nettype none
module hsq_motor_model
   import hsq_pkg::*;
#(
   parameter int HOME_LO = 10000,
   parameter int HOME_HI = 12000,
   parameter int POT_AT  = 20000,
   parameter int IDX_PER = 1000,
   parameter int IDX_WID = 48
) (
   input  wire logic        clk_i,
   input  wire logic        load_i,
   input  wire logic [31:0] pos_i,
   input  wire hsq_motion_s motion_i,
   output logic             forward_overtravel_switch_o,
   output logic             home_switch_input_o,
   output logic             index_pulse_o
);
   int pos;

   initial pos = 0;

   // position follows the commanded speed one step per cycle
   always @(posedge clk_i) begin
      if (load_i)
         pos <= int'(pos_i);
      else if (motion_i.dir_rev === 1'b1)
         pos <= pos - int'(motion_i.speed);
      else
         pos <= pos + int'(motion_i.speed);
   end

   // switch window wider than any braking distance, index wider than one step
   assign home_switch_input_o         = (pos >= HOME_LO) && (pos < HOME_HI);
   assign forward_overtravel_switch_o = (pos >= POT_AT);
   assign index_pulse_o               = (pos % IDX_PER) < IDX_WID;
endmodule
`default_nettype wire

// file: tb/hsq_top_test.sv
// self-checking bench for the homing sequencer, methods 2 to 9
`include "hsq_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module hsq_top_test
   import hsq_pkg::*;
;
   localparam int          TICK = 4;
   localparam logic [15:0] HI   = 16'h0028;
   localparam logic [15:0] LO   = 16'h000a;
   localparam logic [15:0] ACC  = 16'h0007;
   logic        clk_i    = 1'b0;
   logic        resetn_i = 1'b0;
   hsq_bus_s    bus      = '0;
   logic [31:0] reg_rdata_o;
   logic        pot;
   logic        home;
   logic        idx;
   logic        load     = 1'b0;
   logic [31:0] load_pos = '0;
   hsq_motion_s motion_o;
   hsq_motion_s prev     = '0;
   int          n_mismatch = 0;
   int          checks     = 0;
   logic [19:0] seq    = '0;
   logic [3:0]  last_c = '0;
   logic [3:0]  code;

   always #4 clk_i = ~clk_i;

   hsq_top #(.TICK_CYC(TICK)) i_hsq_top (.clk_i(clk_i), .resetn_i(resetn_i), .bus_i(bus),
      .reg_rdata_o(reg_rdata_o), .forward_overtravel_switch_i(pot), .home_switch_input_i(home),
      .index_pulse_i(idx), .motion_o(motion_o));
   hsq_motor_model i_hsq_motor_model (.clk_i(clk_i), .load_i(load), .pos_i(load_pos), .motion_i(motion_o),
      .forward_overtravel_switch_o(pot), .home_switch_input_o(home), .index_pulse_o(idx));

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus <= '0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus <= '0;
      #1 d = reg_rdata_o;
   endtask

   task automatic place(input int p);
      @(posedge clk_i);
      load <= 1'b1;
      load_pos <= p;
      @(posedge clk_i);
      load <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask

   // one homing run from a start position; seq holds one nibble per steady segment
   task automatic run(input logic [7:0] m, input int p, input logic [19:0] exp, input logic lim);
      logic [31:0] v;
      int          n;
      place(p);
      seq = '0;
      last_c = '0;
      wr(`HSQ_OFF_METHOD, {24'h0, m});
      wr(`HSQ_OFF_CTRL, 32'h1);
      n = 0;
      repeat (2) @(negedge clk_i);
      while (motion_o.busy !== 1'b0 && n < 20000) begin
         @(negedge clk_i);
         n++;
      end
      if (n >= 20000) begin
         n_mismatch++;
         $display("unexpected busy after wait: expected 0 seen %b", motion_o.busy);
         final_report();
      end
      chk("done", motion_o.done, 1'b1);
      chk("step order", seq, exp);
      chk("speed at rest", motion_o.speed, 16'h0);
      rd(`HSQ_OFF_STAT, v);
      chk("status", v & 32'hf, {lim, 3'b010});
   endtask

   // steady segments: 4 fwd low, 5 fwd high, 6 rev low, 7 rev high
   always @(negedge clk_i) begin
      if (motion_o.busy === 1'b1 && (motion_o.speed === HI || motion_o.speed === LO)) begin
         code = {2'b01, motion_o.dir_rev, motion_o.speed === HI};
         if (code !== last_c) begin
            seq = {seq[15:0], code};
            last_c = code;
         end
      end
      if (motion_o.busy === 1'b1 && prev.busy === 1'b1 && motion_o.dir_rev === prev.dir_rev &&
          motion_o.speed < prev.speed && motion_o.speed !== LO)
         chk("ramp step", {16'h0, prev.speed - motion_o.speed}, {16'h0, ACC});
      prev = motion_o;
   end

   task automatic t_regs();
      logic [7:0]  ofs [6] = '{`HSQ_OFF_CTRL, `HSQ_OFF_METHOD, `HSQ_OFF_HIGH, `HSQ_OFF_LOW, `HSQ_OFF_ACC,
                               `HSQ_OFF_STAT};
      logic [31:0] rst [6] = '{32'h0, 32'h2, 32'h64, 32'ha, 32'h1, 32'h0};
      logic [7:0]  wa [4]  = '{`HSQ_OFF_HIGH, `HSQ_OFF_LOW, `HSQ_OFF_ACC, 8'h18};
      logic [31:0] we [4]  = '{{16'h0, HI}, {16'h0, LO}, {16'h0, ACC}, 32'h0};
      logic [31:0] v;
      for (int i = 0; i < 6; i++) begin
         rd(ofs[i], v);
         chk("reset value", v, rst[i]);
      end
      for (int i = 0; i < 4; i++)
         wr(wa[i], (i == 3) ? 32'hffff_ffff : we[i]);
      for (int i = 0; i < 4; i++) begin
         rd(wa[i], v);
         chk("read back", v, we[i]);
      end
   endtask

   task automatic t_refuse();
      logic [7:0]  bad [2] = '{8'h01, 8'h0a};
      logic [31:0] v;
      for (int i = 0; i < 2; i++) begin
         wr(`HSQ_OFF_METHOD, {24'h0, bad[i]});
         wr(`HSQ_OFF_CTRL, 32'h1);
         @(negedge clk_i);
         chk("busy on bad method", motion_o.busy, 1'b0);
         rd(`HSQ_OFF_STAT, v);
         chk("status on bad method", v & 32'h7, 32'h4);
      end
   endtask

   task automatic t_abort();
      logic [31:0] v;
      place(5000);
      wr(`HSQ_OFF_METHOD, 32'h3);
      wr(`HSQ_OFF_CTRL, 32'h1);
      repeat (30) @(negedge clk_i);
      chk("busy while running", motion_o.busy, 1'b1);
      wr(`HSQ_OFF_METHOD, 32'h5);
      wr(`HSQ_OFF_CTRL, 32'h2);
      @(negedge clk_i);
      chk("busy after abort", motion_o.busy, 1'b0);
      chk("speed after abort", motion_o.speed, 16'h0);
      rd(`HSQ_OFF_METHOD, v);
      chk("method kept while busy", v, 32'h3);
      rd(`HSQ_OFF_STAT, v);
      chk("status after abort", v & 32'h7, 32'h0);
   endtask

   task automatic t_m2_m3();
      run(`HSQ_M2, 15000, 20'h56, 1'b0);
      run(`HSQ_M2, 21000, 20'h6, 1'b0);
      run(`HSQ_M3, 5000, 20'h56, 1'b0);
      run(`HSQ_M3, 11000, 20'h6, 1'b0);
   endtask

   task automatic t_m4_m6();
      run(`HSQ_M4, 5000, 20'h564, 1'b0);
      run(`HSQ_M4, 11000, 20'h64, 1'b0);
      run(`HSQ_M5, 15000, 20'h74, 1'b0);
      run(`HSQ_M5, 11000, 20'h4, 1'b0);
      run(`HSQ_M6, 15000, 20'h746, 1'b0);
      run(`HSQ_M6, 11000, 20'h46, 1'b0);
   endtask

   task automatic t_m7_m9();
      run(`HSQ_M7, 5000, 20'h56, 1'b0);
      run(`HSQ_M7, 11000, 20'h6, 1'b0);
      run(`HSQ_M7, 13000, 20'h57646, 1'b1);
      run(`HSQ_M8, 5000, 20'h564, 1'b0);
      run(`HSQ_M8, 13000, 20'h5764, 1'b1);
      run(`HSQ_M8, 11000, 20'h64, 1'b0);
      run(`HSQ_M9, 5000, 20'h546, 1'b0);
      run(`HSQ_M9, 13000, 20'h5746, 1'b1);
      run(`HSQ_M9, 11000, 20'h56, 1'b0);
   endtask

   initial begin
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      t_regs();
      t_refuse();
      t_abort();
      t_m2_m3();
      t_m4_m6();
      t_m7_m9();
      final_report();
   end
endmodule
`default_nettype wire
